// *** common/sirc_defines.vh ***
// constants for the serial readout host controller
`ifndef SIRC_DEFINES_VH
`define SIRC_DEFINES_VH
// command byte layout
`define SIRC_CMD_WRITE_BIT   4
`define SIRC_CMD_QUICK_READ  8'h90
`define SIRC_CMD_CTL_WRITE   8'h3A
`define SIRC_CMD_CTL_READ    8'h2A
`define SIRC_CMD_STATUS_READ 8'h05
// conversion control fields
`define SIRC_CTL_MODE_LSB    0
`define SIRC_CTL_MODE_MSB    1
`define SIRC_CTL_ACC_LSB     4
`define SIRC_CTL_ACC_MSB     5
`define SIRC_CTL_MODE_RESET  2'h0
// host register offsets
`define SIRC_REG_CTRL        4'h0
`define SIRC_REG_TXDATA      4'h1
`define SIRC_REG_STATUS      4'h2
`define SIRC_REG_RXI         4'h3
`define SIRC_REG_RXQ         4'h4
`define SIRC_REG_DIV         4'h5
// reset values
`define SIRC_DIV_RESET       8'h07
// timing: link clock least period and least deselect time
`define SIRC_SCK_PERIOD_NS   125
`define SIRC_CS_IDLE_NS      50
`define SIRC_CLK_NS          8
`define SIRC_CS_IDLE_CYC     ((`SIRC_CS_IDLE_NS + `SIRC_CLK_NS - 1) / `SIRC_CLK_NS)
`endif

// *** dv/sirc_dev_model.sv ***
// behavioural model of the sensor serial port and converter
`timescale 1ns/1ps
module sirc_dev_model #(
    parameter logic [15:0] I_RES   = 16'h0ABC, // accumulated i result
    parameter logic [15:0] Q_RES   = 16'h1357, // accumulated q result
    parameter int          CONV_NS = 20000     // settle plus accumulation time
) (
    // serial link
    input  wire logic spi_cs,
    input  wire logic spi_sck,
    input  wire logic spi_mosi,
    output logic      spi_miso
);
    logic [7:0]  cmd = 0;                      // received command
    logic [15:0] wdat = 0, ctl = 0;            // write data, conversion control
    logic [15:0] ival = 0, qval = 0;           // results
    logic [31:0] tx = 0;                       // outgoing data
    logic        done = 0, armed = 1;          // complete flag, reset seen
    int          cnt = 0;                      // rising edges this selection
    initial spi_miso = 0;
    // select restarts count and drops partial data
    always @(posedge spi_cs)
    begin
        cnt = 0;
        wdat = 0;
    end
    // command echo
    always @* if (spi_cs && cnt < 8) spi_miso = spi_mosi;
    // sample on rising edge, msb first
    always @(posedge spi_sck) if (spi_cs)
    begin
        if (cnt < 8) cmd = {cmd[6:0], spi_mosi};
        else if (cnt < 24) wdat = {wdat[14:0], spi_mosi};
        cnt = cnt + 1;
        if (cnt == 8) tx = cmd == 8'h90 ? {ival, qval} : cmd[4] ? 0 :
            cmd == 8'h2A ? {ctl, 16'h0} : cmd == 8'h05 ? {15'h0, done, 16'h0} : 0;
    end
    // shift out on falling edge; past the end zero or hold
    always @(negedge spi_sck) if (spi_cs && cnt >= 8)
    begin
        if (cnt < (cmd == 8'h90 ? 40 : 24)) spi_miso = tx[31];
        else if (cmd[4] && cmd != 8'h90) spi_miso = 0;
        tx = tx << 1;
    end
    // deselect: pull-down level, finish the command
    always @(negedge spi_cs)
    begin
        spi_miso = 0;
        if (cmd == 8'h90 && cnt >= 40) {ival, qval, done, armed} = 34'h1;
        if (cmd == 8'h3A && cnt > 8)
        begin
            ctl = cnt < 24 ? wdat << (24 - cnt) : wdat;
            done = 0;
            if (ctl[1:0] == 2'h0) armed = 1;
            else if (armed)
            begin
                armed = 0;
                fork #CONV_NS {ival, qval, done} = {I_RES, Q_RES, 1'b1}; join_none
            end
        end
    end
endmodule

// *** dv/sirc_host_assertions.sv ***
// port checker for the serial readout host controller
`timescale 1ns/1ps
`include "sirc_defines.vh"
module sirc_host_chk #(
    parameter DIV_W = 8
) (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // register port
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    // serial link
    input wire logic        spi_cs,
    input wire logic        spi_sck,
    input wire logic        spi_mosi,
    input wire logic        spi_miso
);
    // ====================
    // helper state
    logic [7:0]  cmd;   // command of the running frame
    logic [15:0] txd;   // write data
    logic [5:0]  nrise; // rising clock edges seen in frame
    logic [3:0]  idle;  // cycles since deselect, saturating
    logic        sck_q; // last clock level
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // follow the frame
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {cmd, txd, nrise, sck_q} <= '0;
            idle <= 4'hF;
        end
        else
        begin
            sck_q <= spi_sck;
            idle  <= spi_cs ? 4'h0 : (idle == 4'hF ? idle : idle + 4'h1);
            if (reg_write && reg_addr == `SIRC_REG_TXDATA) txd <= reg_wdata[15:0];
            if (reg_write && reg_addr == `SIRC_REG_CTRL && idle > 4'h7) cmd <= reg_wdata[7:0];
            if (!spi_cs) nrise <= 6'h00;
            else if (spi_sck && !sck_q) nrise <= nrise + 6'h01;
        end
    end
    // ====================
    // assertions
    cs_start_a: assert property (reg_write && reg_addr == `SIRC_REG_CTRL && idle > 4'h7 |=> spi_cs)
        else $error("no select after start");
    cs_cause_a: assert property ($rose(spi_cs) |-> $past(reg_write) && $past(reg_addr) == 4'h0)
        else $error("select without start");
    sck_idle_a: assert property (!spi_cs |-> !spi_sck)
        else $error("clock moves while deselected");
    mosi_hold_a: assert property (spi_sck |-> $stable(spi_mosi))
        else $error("data moved while clock high");
    cmd_bits_a: assert property ($rose(spi_sck) && nrise < 6'd8 |-> spi_mosi == cmd[3'd7 - nrise[2:0]])
        else $error("command bit wrong");
    wdata_bits_a: assert property ($rose(spi_sck) && nrise > 6'd7 && cmd[4]
        && nrise < 6'd24 && cmd != 8'h90 |-> spi_mosi == txd[5'd23 - nrise[4:0]])
        else $error("write data bit wrong");
    read_zero_a: assert property ($rose(spi_sck) && nrise > 6'd7 && (!cmd[4] || cmd == 8'h90) |-> !spi_mosi)
        else $error("read sends nonzero");
    frame_len_a: assert property ($fell(spi_cs) |-> nrise == (cmd == 8'h90 ? 6'd40 : 6'd24))
        else $error("frame length wrong");
    cs_gap_a: assert property ($fell(spi_cs) |-> !spi_cs [*7])
        else $error("deselect too short");
    cover property ($fell(spi_cs) && cmd == 8'h90);
    cover property ($fell(spi_cs) && cmd == 8'h3A);
    cover property ($fell(spi_cs) && cmd == 8'h05);
endmodule
bind sirc_host sirc_host_chk #(.DIV_W(DIV_W)) u_chk (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .spi_cs(spi_cs), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso));

// *** dv/testbench.sv ***
// self-checking bench for the serial readout host controller
`timescale 1ns/1ps
`include "sirc_defines.vh"
module testbench;
    localparam logic [15:0] I_RES = 16'h0ABC; // model results
    localparam logic [15:0] Q_RES = 16'h1357;
    logic        clock = 0, rst_n = 0, reg_write = 0, reg_read = 0;
    logic [3:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, rd_val;
    wire         spi_cs, spi_sck, spi_mosi, spi_miso;
    int          bad_count = 0, tests_run = 0;
    always #4 clock = ~clock;
    sirc_host dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .spi_cs(spi_cs),
        .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
    sirc_dev_model #(.I_RES(I_RES), .Q_RES(Q_RES)) model (.spi_cs(spi_cs), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso));
    // ====================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock) reg_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock) reg_read <= 1'b0;
        #1 rd_val = reg_rdata;
        @(posedge clock);
    endtask
    // one frame, then status and received words
    task automatic xfer(input logic [7:0] c, input logic [15:0] d, input logic [15:0] e);
        int n;
        n = 0;
        wr(`SIRC_REG_TXDATA, {16'h0, d});
        wr(`SIRC_REG_CTRL, {24'h0, c});
        rd_val = 0;
        while (rd_val[0] !== 1'b1 && n < 1000)
        begin
            rd(`SIRC_REG_STATUS);
            n++;
        end
        check(rd_val, {20'h0, c, 1'b0, c == 8'h3A, 2'b01});
        rd(`SIRC_REG_RXQ);
        check({16'h0, rd_val[15:0]}, {16'h0, e});
        if (c == 8'h90) rd(`SIRC_REG_RXI);
        if (c == 8'h90) check({16'h0, rd_val[15:0]}, {16'h0, d});
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ====================
    // main sequence
    initial
    begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(`SIRC_REG_DIV);
        check(rd_val, {24'h0, `SIRC_DIV_RESET});
        rd(`SIRC_REG_STATUS);
        check(rd_val, 32'h0);
        xfer(8'h3A, 16'h0000, 16'h0000);
        xfer(8'h3A, 16'h0011, 16'h0000);
        xfer(8'h2A, 16'h0000, 16'h0011);
        xfer(8'h05, 16'h0000, 16'h0000);
        wr(`SIRC_REG_DIV, 32'h0000_0009);
        rd(`SIRC_REG_DIV);
        check(rd_val, 32'h0000_0009);
        xfer(8'h2A, 16'h0000, 16'h0011);
        wr(`SIRC_REG_DIV, {24'h0, `SIRC_DIV_RESET});
        repeat (3000) @(posedge clock);
        xfer(8'h05, 16'h0000, 16'h0001);
        xfer(8'h90, I_RES, Q_RES);
        xfer(8'h05, 16'h0000, 16'h0000);
        xfer(8'h90, 16'h0000, 16'h0000);
        report_and_stop();
    end
    // watchdog
    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end
endmodule

// *** rtl/sirc_host.v ***
// host controller that drives the sensor serial port as master
`timescale 1ns/1ps
`include "sirc_defines.vh"

module sirc_host #(
    parameter DIV_W = 8                    // width of the half-period divider
) (
    // clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // software register port
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [31:0] reg_rdata,
    // serial link to the device
    output reg         spi_cs,
    output reg         spi_sck,
    output reg         spi_mosi,
    input  wire        spi_miso
);

    // =========================================================
    // state encodings
    // =========================================================
    localparam ST_IDLE  = 2'h0;            // deselected, waiting for a go
    localparam ST_LEAD  = 2'h1;            // chip select high before first edge
    localparam ST_SHIFT = 2'h2;            // clocking bits
    localparam ST_GAP   = 2'h3;            // forced deselect time

    // =========================================================
    // timing constants
    // =========================================================
    // deselect hold after a frame, in system clock cycles
    localparam [7:0]       CS_IDLE   = `SIRC_CS_IDLE_CYC;
    // serial clock half period after reset, in clock cycles minus one
    localparam [DIV_W-1:0] DIV_RESET = `SIRC_DIV_RESET;
    // frame lengths in serial clock periods
    localparam [5:0]       LEN_SHORT = 6'd24;
    localparam [5:0]       LEN_QUICK = 6'd40;

    // =========================================================
    // registers
    // =========================================================
    reg [1:0]       state;                 // transfer state
    reg [7:0]       cmd;                   // command byte to send
    reg [15:0]      wdata;                 // write data word
    reg [31:0]      rx_shift;              // received data after the echo
    reg [7:0]       echo;                  // first received byte
    reg [5:0]       bit_cnt;               // bits left in the frame
    reg [5:0]       bit_total;             // frame length in bits
    reg [39:0]      tx_shift;              // outgoing frame, msb first
    reg [DIV_W-1:0] div_cfg;               // half-period in clock cycles minus one
    reg [DIV_W-1:0] div_cnt;               // divider counter
    reg [7:0]       gap_cnt;               // deselect timer
    reg             busy;                  // transfer in progress
    reg             done;                  // sticky finished flag
    reg             echo_err;              // echo did not match command
    reg             miso_meta;             // first synchroniser stage
    reg             miso_sync;             // second synchroniser stage
    reg             ctl_write;             // last frame wrote control register

    wire            tick;                  // one-cycle half-period enable
    wire [5:0]      next_len;              // frame length of the requested command
    wire            go;                    // software start request
    wire            is_quick;              // requested command is the combined read
    wire            is_write;              // requested command carries write data
    wire            in_echo;               // next rising edge is inside the echo byte
    wire            frame_end;             // every rising edge of the frame is given

    // =========================================================
    // frame length from the command byte
    // =========================================================
    // combined read has bit four set yet sends only zero bytes
    assign is_quick  = (reg_wdata[7:0] == `SIRC_CMD_QUICK_READ);
    assign is_write  = reg_wdata[`SIRC_CMD_WRITE_BIT] && !is_quick;
    // quick read is five bytes, all others three
    assign next_len  = is_quick ? LEN_QUICK : LEN_SHORT;
    // a start while a frame runs is dropped
    assign go        = reg_write && (reg_addr == `SIRC_REG_CTRL) && !busy;
    // one-cycle enable per serial clock half period
    assign tick      = (div_cnt == {DIV_W{1'b0}});
    // rising edges still inside the echo byte
    assign in_echo   = ((bit_total - bit_cnt) < 6'd8);
    // all rising edges of the frame have been given
    assign frame_end = (bit_cnt == 6'd0);

    // =========================================================
    // frame walk
    // =========================================================
    // a start write raises select on the next clock; one clock later
    // the first command bit is on the data line with the serial clock
    // low; each tick then toggles the serial clock, rising edges take
    // the device bit and falling edges present the next bit; after the
    // last rising edge the next tick drops clock and select together,
    // and select stays low for the deselect hold before done is set

    // =========================================================
    // synchronise the device output
    // =========================================================
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            miso_meta <= 1'b0;
            miso_sync <= 1'b0;
        end
        else
        begin
            // the device output is not timed to our clock
            miso_meta <= spi_miso;
            miso_sync <= miso_meta;
        end
    end

    // =========================================================
    // half-period divider, runs only while shifting
    // =========================================================
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            div_cnt <= {DIV_W{1'b0}};
        // reload outside shifting and after each tick
        else if (state != ST_SHIFT || tick)
            div_cnt <= div_cfg;
        else
            div_cnt <= div_cnt - {{(DIV_W-1){1'b0}}, 1'b1};
    end

    // =========================================================
    // transfer engine
    // =========================================================
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= ST_IDLE;
            spi_cs    <= 1'b0;
            spi_sck   <= 1'b0;
            spi_mosi  <= 1'b0;
            tx_shift  <= 40'h00_0000_0000;
            rx_shift  <= 32'h0000_0000;
            echo      <= 8'h00;
            bit_cnt   <= 6'h00;
            bit_total <= 6'h00;
            gap_cnt   <= 8'h00;
            busy      <= 1'b0;
            done      <= 1'b0;
            echo_err  <= 1'b0;
            cmd       <= 8'h00;
            ctl_write <= 1'b0;
        end
        else
        begin
            // reading status clears done, a finishing frame wins
            if (reg_read && reg_addr == `SIRC_REG_STATUS)
                done <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    // park the link deselected with the clock low
                    spi_cs  <= 1'b0;
                    spi_sck <= 1'b0;
                    if (go)
                    begin
                        // a control change must follow a mode-zero write;
                        // software sequencing keeps that order
                        // a new single conversion needs that reset or a combined
                        // read first; software keeps this too
                        cmd       <= reg_wdata[7:0];
                        bit_total <= next_len;
                        bit_cnt   <= next_len;
                        // write data follows command, reads send zeros
                        if (is_write)
                            tx_shift <= {reg_wdata[7:0], wdata, 16'h0000};
                        else
                            tx_shift <= {reg_wdata[7:0], 32'h0000_0000};
                        ctl_write <= (reg_wdata[7:0] == `SIRC_CMD_CTL_WRITE);
                        busy      <= 1'b1;
                        echo_err  <= 1'b0;
                        rx_shift  <= 32'h0000_0000;
                        spi_cs    <= 1'b1;
                        state     <= ST_LEAD;
                    end
                end
                ST_LEAD:
                begin
                    // first bit presented with clock low
                    spi_mosi <= tx_shift[39];
                    tx_shift <= {tx_shift[38:0], 1'b0};
                    state    <= ST_SHIFT;
                end
                ST_SHIFT:
                begin
                    // one serial clock edge per tick
                    if (tick)
                    begin
                        if (!spi_sck)
                        begin
                            // rising edge: sample device bit
                            spi_sck <= 1'b1;
                            // echo byte first, then the data words
                            if (in_echo)
                                echo <= {echo[6:0], miso_sync};
                            else
                                rx_shift <= {rx_shift[30:0], miso_sync};
                            bit_cnt <= bit_cnt - 6'd1;
                        end
                        else if (frame_end)
                        begin
                            // frame complete, drop select
                            spi_sck  <= 1'b0;
                            spi_cs   <= 1'b0;
                            spi_mosi <= 1'b0;
                            gap_cnt  <= CS_IDLE;
                            echo_err <= (echo != cmd);
                            state    <= ST_GAP;
                        end
                        else
                        begin
                            // falling edge: next bit out
                            spi_sck  <= 1'b0;
                            spi_mosi <= tx_shift[39];
                            tx_shift <= {tx_shift[38:0], 1'b0};
                        end
                    end
                end
                ST_GAP:
                begin
                    // hold deselect so the next frame starts clean
                    if (gap_cnt == 8'h00)
                    begin
                        busy  <= 1'b0;
                        done  <= 1'b1;
                        state <= ST_IDLE;
                    end
                    else
                        gap_cnt <= gap_cnt - 8'h01;
                end
                default:
                    // unused code falls back to idle
                    state <= ST_IDLE;
            endcase
        end
    end

    // =========================================================
    // software writable registers
    // =========================================================
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdata   <= 16'h0000;
            div_cfg <= DIV_RESET;
        end
        else if (reg_write)
        begin
            // write data, taken when the next frame starts
            if (reg_addr == `SIRC_REG_TXDATA)
                wdata <= reg_wdata[15:0];
            // a divider change is dropped while a frame runs
            if (reg_addr == `SIRC_REG_DIV && !busy)
                div_cfg <= reg_wdata[DIV_W-1:0];
        end
    end

    // =========================================================
    // read data, one cycle after the strobe
    // =========================================================
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_read)
        begin
            case (reg_addr)
                `SIRC_REG_CTRL:   reg_rdata <= {24'h00_0000, cmd};
                `SIRC_REG_TXDATA: reg_rdata <= {16'h0000, wdata};
                `SIRC_REG_STATUS:
                begin
                    // echo byte, control-write flag, echo error, sticky done
                    reg_rdata <= {20'h0_0000, echo, 1'b0, ctl_write, echo_err, done};
                end
                // i word, then q word or plain read word
                `SIRC_REG_RXI:    reg_rdata <= {16'h0000, rx_shift[31:16]};
                `SIRC_REG_RXQ:    reg_rdata <= {16'h0000, rx_shift[15:0]};
                `SIRC_REG_DIV:    reg_rdata <= {{(32-DIV_W){1'b0}}, div_cfg};
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            // read data stand for one cycle only
            reg_rdata <= 32'h0000_0000;
    end

    // =========================================================
    // software sequencing notes
    // =========================================================
    // the controller does not police the device's conversion rules;
    // software keeps them frame by frame:
    //   1. write the transmit word with the mode bits zero and start a
    //      control write, which resets the converter and accumulators
    //   2. after done, write the transmit word with the new fields and
    //      a mode, and start a second control write
    //   3. poll the device completion command until its bit shows
    //   4. start a combined read; it hands over both words of one
    //      sample and rearms the device for the next single conversion
    // a start while busy is dropped without notice, so wait for done
    // divider writes are dropped while busy for the same reason
    // keep the half period at four clocks or more: the device bit then
    // has passed both input flops before the rising edge samples it
    // busy is not shown in status; done and select tell the same story

endmodule
